// file: rtl/cad_top.sv
// alarm qualification and changeover decision for a two-input changeover
// analyser inputs are asynchronous and synchronised here; config is on ref_clk
//
// Function
// - enabled alarm drives selection and card status
// - levels are 1, 2 or off
// - no-signal alarm fixed level 1, always on
// - input level is most significant active level
// - input 1 clean selects 1; level1 prefers 2
// - input 1 level2 only: decide by input 2
// - video error always enabled, default level 1; its level here comes from alarm_level alone, CAD_VIDERR_LEVEL_RST is unused
// - video error qualified over configured duration
// - long video/freeze durations add half second
// - transport mode leaves only video error and no-signal
// - format mismatch raised half second after difference
// - expected format offers eight choices
// - active alarm other than no-signal, video error or timing drives chosen indicator colour
// - timing alarm over two lines, never selects
// - black below threshold for set time plus half
// - black clears after clear duration of picture
// - freeze threshold 0..15, zero exact match
// - freeze set and clear durations
// - audio group loss after configured duration
// - channel silence below threshold plus half second
// - silence only on linear pcm channels
`timescale 1ns/100ps
`include "cad_map.svh"
module cad_top #(
  parameter int TICK_CYCLES = `CAD_TICK_CYCLES,
  parameter int NA          = `CAD_NUM_ALARMS,
  parameter int NG          = `CAD_NUM_GROUPS,
  parameter int NC          = `CAD_NUM_CHANNELS,
  parameter int DW          = `CAD_DUR_W,
  parameter int LW          = `CAD_CH_LEVEL_W
) (
  input  wire logic                    ref_clk,
  input  wire logic                    rst,
  // analyser inputs, one lane per video input
  input  wire logic [1:0]              sig_present,
  input  wire logic [1:0]              vid_err,
  input  wire logic [1:0][2:0]         fmt_detected,
  input  wire logic [1:0][2:0]         timing_offset_lines,
  input  wire logic [1:0][9:0]         luma_mv,
  input  wire logic [1:0][3:0]         frame_diff,
  input  wire logic [1:0][NG-1:0]      grp_present,
  input  wire logic [1:0][NC*LW-1:0]   ch_level_db,
  input  wire logic [1:0][NC-1:0]      ch_is_pcm,
  // configuration
  input  wire logic                    ts_mode,
  input  wire logic [1:0][NA-1:0]      alarm_enable,
  input  wire logic [1:0][NA*2-1:0]    alarm_level,
  input  wire logic [1:0][NA*2-1:0]    alarm_led,
  input  wire logic [1:0][2:0]         fmt_expected,
  input  wire logic [1:0][DW-1:0]      viderr_dur,
  input  wire logic [1:0][9:0]         black_thresh_mv,
  input  wire logic [1:0][DW-1:0]      black_set_dur,
  input  wire logic [1:0][DW-1:0]      black_clr_dur,
  input  wire logic [1:0][3:0]         freeze_thresh,
  input  wire logic [1:0][DW-1:0]      freeze_set_dur,
  input  wire logic [1:0][DW-1:0]      freeze_clr_dur,
  input  wire logic [1:0][NG*DW-1:0]   grp_dur,
  input  wire logic [1:0][LW-1:0]      silence_thresh_db,
  input  wire logic [1:0][DW-1:0]      silence_dur,
  // status and decision
  output logic [1:0][NA-1:0]           alarm_status,
  output logic [1:0][1:0]              input_level,
  output logic [1:0]                   led_colour,
  output logic                         select_in2
);

  localparam logic [DW-1:0] HALF_SEC = DW'(`CAD_HALF_SEC_UNITS);
  localparam logic [DW-1:0] ONE_SEC  = DW'(`CAD_ONE_SEC_UNITS);
  localparam logic [DW-1:0] NO_DELAY = '0;

  // two-flop synchronisers for every analyser input
  logic [1:0]            sp_m_reg, sp_reg, ve_m_reg, ve_reg;
  logic [1:0][2:0]       fd_m_reg, fd_reg, to_m_reg, to_reg;
  logic [1:0][9:0]       lm_m_reg, lm_reg;
  logic [1:0][3:0]       df_m_reg, df_reg;
  logic [1:0][NG-1:0]    gp_m_reg, gp_reg;
  logic [1:0][NC*LW-1:0] cl_m_reg, cl_reg;
  logic [1:0][NC-1:0]    pc_m_reg, pc_reg;

  // first stage read only by the second; healthy reset levels keep alarms quiet after reset
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sp_m_reg <= '1;
      sp_reg   <= '1;
      ve_m_reg <= '0;
      ve_reg   <= '0;
      fd_m_reg <= '0;
      fd_reg   <= '0;
      to_m_reg <= '0;
      to_reg   <= '0;
      lm_m_reg <= '1;
      lm_reg   <= '1;
      df_m_reg <= '1;
      df_reg   <= '1;
      gp_m_reg <= '1;
      gp_reg   <= '1;
      cl_m_reg <= '0;
      cl_reg   <= '0;
      pc_m_reg <= '0;
      pc_reg   <= '0;
    end else begin
      sp_m_reg <= sig_present;
      sp_reg   <= sp_m_reg;
      ve_m_reg <= vid_err;
      ve_reg   <= ve_m_reg;
      fd_m_reg <= fmt_detected;
      fd_reg   <= fd_m_reg;
      to_m_reg <= timing_offset_lines;
      to_reg   <= to_m_reg;
      lm_m_reg <= luma_mv;
      lm_reg   <= lm_m_reg;
      df_m_reg <= frame_diff;
      df_reg   <= df_m_reg;
      gp_m_reg <= grp_present;
      gp_reg   <= gp_m_reg;
      cl_m_reg <= ch_level_db;
      cl_reg   <= cl_m_reg;
      pc_m_reg <= ch_is_pcm;
      pc_reg   <= pc_m_reg;
    end
  end

  // 10 ms time base shared by all duration counters
  logic [31:0] tick_cnt_reg;
  logic        tick_reg;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      tick_cnt_reg <= '0;
      tick_reg     <= 1'b0;
    end else if (tick_cnt_reg >= 32'(TICK_CYCLES - 1)) begin
      tick_cnt_reg <= '0;
      tick_reg     <= 1'b1;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 32'h1;
      tick_reg     <= 1'b0;
    end
  end

  // expected format check; generic sd/hd accept any format of that class
  function automatic logic fmt_match(input logic [2:0] exp_f, input logic [2:0] det_f);
    logic det_sd;
    det_sd = (det_f == cad_pkg::CAD_FMT_525) || (det_f == cad_pkg::CAD_FMT_625);
    if (exp_f == cad_pkg::CAD_FMT_SD) begin
      fmt_match = det_sd;
    end else if (exp_f == cad_pkg::CAD_FMT_HD) begin
      fmt_match = !det_sd && (det_f < cad_pkg::CAD_FMT_SD);
    end else begin
      fmt_match = (exp_f == det_f);
    end
  endfunction

  // half-second guard on durations of one second and more
  function automatic logic [DW-1:0] long_guard(input logic [DW-1:0] d);
    long_guard = (d >= ONE_SEC) ? DW'(d + HALF_SEC) : d;
  endfunction

  logic [1:0][NA-1:0] raw_act;
  logic [1:0][NA-1:0] eff_en;
  logic [1:0]         lvl1_any, lvl2_any;
  logic [1:0][1:0]    led_in;

  genvar gi, ga;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_in
      logic        nosig_reg, timing_reg;
      logic [NA-1:0] sel1, sel2;

      // loss of signal and timing offset act without a duration
      always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
          nosig_reg  <= 1'b0;
          timing_reg <= 1'b0;
        end else begin
          nosig_reg  <= ~sp_reg[gi];
          timing_reg <= (to_reg[gi] > `CAD_TIMING_LIMIT);
        end
      end
      assign raw_act[gi][`CAD_A_NOSIG]  = nosig_reg;
      assign raw_act[gi][`CAD_A_TIMING] = timing_reg;

      cad_qual #(.W(DW)) u_viderr (
        .ref_clk   (ref_clk),
        .rst       (rst),
        .tick      (tick_reg),
        .cond      (ve_reg[gi]),
        .set_units (long_guard(viderr_dur[gi])),
        .clr_units (NO_DELAY),
        .active    (raw_act[gi][`CAD_A_VIDERR])
      );

      cad_qual #(.W(DW)) u_fmt (
        .ref_clk   (ref_clk),
        .rst       (rst),
        .tick      (tick_reg),
        .cond      (sp_reg[gi] && !fmt_match(fmt_expected[gi], fd_reg[gi])),
        .set_units (HALF_SEC),
        .clr_units (NO_DELAY),
        .active    (raw_act[gi][`CAD_A_FMT])
      );

      cad_qual #(.W(DW)) u_black (
        .ref_clk   (ref_clk),
        .rst       (rst),
        .tick      (tick_reg),
        .cond      (lm_reg[gi] < black_thresh_mv[gi]),
        .set_units (DW'(black_set_dur[gi] + HALF_SEC)),
        .clr_units (black_clr_dur[gi]),
        .active    (raw_act[gi][`CAD_A_BLACK])
      );

      // frame difference at or under threshold counts as frozen
      cad_qual #(.W(DW)) u_freeze (
        .ref_clk   (ref_clk),
        .rst       (rst),
        .tick      (tick_reg),
        .cond      (df_reg[gi] <= freeze_thresh[gi]),
        .set_units (long_guard(freeze_set_dur[gi])),
        .clr_units (freeze_clr_dur[gi]),
        .active    (raw_act[gi][`CAD_A_FREEZE])
      );

      for (ga = 0; ga < NG; ga++) begin : g_grp
        cad_qual #(.W(DW)) u_grp (
          .ref_clk   (ref_clk),
          .rst       (rst),
          .tick      (tick_reg),
          .cond      (~gp_reg[gi][ga]),
          .set_units (grp_dur[gi][ga*DW +: DW]),
          .clr_units (NO_DELAY),
          .active    (raw_act[gi][`CAD_A_GRP0 + ga])
        );
      end

      // non-pcm payloads never count as silent
      for (ga = 0; ga < NC; ga++) begin : g_sil
        cad_qual #(.W(DW)) u_sil (
          .ref_clk   (ref_clk),
          .rst       (rst),
          .tick      (tick_reg),
          .cond      (pc_reg[gi][ga] &&
                      (cl_reg[gi][ga*LW +: LW] < silence_thresh_db[gi])),
          .set_units (DW'(silence_dur[gi] + HALF_SEC)),
          .clr_units (NO_DELAY),
          .active    (raw_act[gi][`CAD_A_SIL0 + ga])
        );
      end

      // effective enables and level masks per alarm
      always_comb begin
        for (int a = 0; a < NA; a++) begin
          eff_en[gi][a] = alarm_enable[gi][a];
          sel1[a]       = (alarm_level[gi][a*2 +: 2] == cad_pkg::CAD_LVL_1);
          sel2[a]       = (alarm_level[gi][a*2 +: 2] == cad_pkg::CAD_LVL_2);
          if (ts_mode && (a != `CAD_A_VIDERR) && (a != `CAD_A_NOSIG)) begin
            eff_en[gi][a] = 1'b0;
          end
        end
        eff_en[gi][`CAD_A_NOSIG]  = 1'b1;
        sel1[`CAD_A_NOSIG]        = 1'b1;
        sel2[`CAD_A_NOSIG]        = 1'b0;
        eff_en[gi][`CAD_A_VIDERR] = 1'b1;
        eff_en[gi][`CAD_A_TIMING] = !ts_mode;
        sel1[`CAD_A_TIMING]       = 1'b0;
        sel2[`CAD_A_TIMING]       = 1'b0;
      end

      // reduce the enabled active alarms to one input level
      assign lvl1_any[gi] = |(raw_act[gi] & eff_en[gi] & sel1);
      assign lvl2_any[gi] = |(raw_act[gi] & eff_en[gi] & sel2);

      // most severe colour among active configurable alarms
      always_comb begin
        led_in[gi] = cad_pkg::CAD_LED_GREEN;
        for (int a = 0; a < NA; a++) begin
          if ((a != `CAD_A_NOSIG) && (a != `CAD_A_VIDERR) && (a != `CAD_A_TIMING) &&
              raw_act[gi][a] && eff_en[gi][a] &&
              (alarm_led[gi][a*2 +: 2] > led_in[gi])) begin
            led_in[gi] = alarm_led[gi][a*2 +: 2];
          end
        end
      end
    end
  endgenerate

  // registered status outputs; level has no bearing on status
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      alarm_status <= '0;
      input_level  <= '0;
      led_colour   <= cad_pkg::CAD_LED_GREEN;
    end else begin
      for (int i = 0; i < 2; i++) begin
        alarm_status[i] <= raw_act[i] & eff_en[i];
        input_level[i]  <= lvl1_any[i] ? cad_pkg::CAD_LVL_1 :
                           (lvl2_any[i] ? cad_pkg::CAD_LVL_2 : cad_pkg::CAD_LVL_OFF);
      end
      led_colour <= (led_in[0] > led_in[1]) ? led_in[0] : led_in[1];
    end
  end

  // changeover truth table; ties at level 1 or 2 keep the current input, a clean input 1 is always selected
  cad_pkg::cad_sel_e sel_reg, sel_next;

  always_comb begin
    sel_next = sel_reg;
    if (!lvl1_any[0] && !lvl2_any[0]) begin
      sel_next = cad_pkg::CAD_SEL_IN1;
    end else if (lvl1_any[0]) begin
      if (!lvl1_any[1]) begin
        sel_next = cad_pkg::CAD_SEL_IN2;
      end else begin
        sel_next = sel_reg;
      end
    end else begin
      if (!lvl1_any[1] && !lvl2_any[1]) begin
        sel_next = cad_pkg::CAD_SEL_IN2;
      end else if (lvl1_any[1]) begin
        sel_next = cad_pkg::CAD_SEL_IN1;
      end else begin
        sel_next = sel_reg;
      end
    end
  end

  // selector state; input 1 after reset
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sel_reg <= cad_pkg::CAD_SEL_IN1;
    end else begin
      sel_reg <= sel_next;
    end
  end

  assign select_in2 = (sel_reg == cad_pkg::CAD_SEL_IN2);

endmodule // cad_top

// file: rtl/cad_map.svh
// offsets, field positions, reset values and timing counts of the alarm decision block
// assumes a 40 mhz ref_clk and durations given in 10 ms units
`ifndef CAD_MAP_SVH
`define CAD_MAP_SVH

`define CAD_CLK_KHZ        40000
`define CAD_TICK_US        10000
`define CAD_TICK_CYCLES    ((`CAD_TICK_US * `CAD_CLK_KHZ) / 1000)
`define CAD_DUR_W          15
`define CAD_HALF_SEC_MS    500
`define CAD_ONE_SEC_MS     1000
`define CAD_UNIT_MS        10
`define CAD_HALF_SEC_UNITS (`CAD_HALF_SEC_MS / `CAD_UNIT_MS)
`define CAD_ONE_SEC_UNITS  (`CAD_ONE_SEC_MS / `CAD_UNIT_MS)
`define CAD_TIMING_LIMIT   3'h2
`define CAD_NUM_ALARMS     26
`define CAD_NUM_GROUPS     4
`define CAD_NUM_CHANNELS   16
`define CAD_CH_LEVEL_W     8
`define CAD_A_NOSIG        0
`define CAD_A_VIDERR       1
`define CAD_A_FMT          2
`define CAD_A_TIMING       3
`define CAD_A_BLACK        4
`define CAD_A_FREEZE       5
`define CAD_A_GRP0         6
`define CAD_A_SIL0         10
`define CAD_VIDERR_LEVEL_RST 2'h1

`endif

// file: rtl/cad_pkg.sv
// types shared by the alarm decision block
// constants live in cad_map.svh
package cad_pkg;

  // alarm significance, one per alarm
  typedef enum logic [1:0] {
    CAD_LVL_OFF = 2'h0,
    CAD_LVL_1   = 2'h1,
    CAD_LVL_2   = 2'h2
  } cad_lvl_e;

  // card-edge indicator colour, ordered by severity
  typedef enum logic [1:0] {
    CAD_LED_GREEN     = 2'h0,
    CAD_LED_YELLOW    = 2'h1,
    CAD_LED_RED       = 2'h2,
    CAD_LED_FLASH_RED = 2'h3
  } cad_led_e;

  // expected / detected video format
  typedef enum logic [2:0] {
    CAD_FMT_525     = 3'h0,
    CAD_FMT_625     = 3'h1,
    CAD_FMT_1080I59 = 3'h2,
    CAD_FMT_1080I50 = 3'h3,
    CAD_FMT_720P59  = 3'h4,
    CAD_FMT_720P50  = 3'h5,
    CAD_FMT_SD      = 3'h6,
    CAD_FMT_HD      = 3'h7
  } cad_fmt_e;

  // output selector state
  typedef enum logic [1:0] {
    CAD_SEL_IN1 = 2'b01,
    CAD_SEL_IN2 = 2'b10
  } cad_sel_e;

endpackage

// file: rtl/cad_qual.sv
// duration qualifier: raises after a condition holds for set time, clears after
// it is absent for clear time; assumes tick is a one-cycle pulse per time unit
`timescale 1ns/100ps
module cad_qual #(
  parameter int W = 15
) (
  input  wire logic         ref_clk,
  input  wire logic         rst,
  input  wire logic         tick,
  input  wire logic         cond,
  input  wire logic [W-1:0] set_units,
  input  wire logic [W-1:0] clr_units,
  output logic              active
);

  logic [W-1:0] cnt_reg;
  logic         active_reg;
  logic         run;

  // count while the state is challenged, otherwise restart from zero
  assign run = active_reg ? ~cond : cond;

  // duration counter; any break of the condition restarts it
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cnt_reg <= '0;
    end else if (!run || (active_reg ? (cnt_reg >= clr_units) : (cnt_reg >= set_units))) begin
      cnt_reg <= '0;
    end else if (tick && (cnt_reg != {W{1'b1}})) begin
      cnt_reg <= cnt_reg + 1'b1;
    end
  end

  // alarm state flips once the count reaches its duration
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      active_reg <= 1'b0;
    end else if (!active_reg && cond && (cnt_reg >= set_units)) begin
      active_reg <= 1'b1;
    end else if (active_reg && !cond && (cnt_reg >= clr_units)) begin
      active_reg <= 1'b0;
    end
  end

  assign active = active_reg;

endmodule // cad_qual

// file: testbench/cad_top_properties.sv
// port-level timing relations of the changeover decision block
// assumes one ref_clk domain and analyser pins synchronised inside the design
`timescale 1ns/100ps
module cad_top_properties #(
  parameter int NA = 26
) (
  input wire logic                ref_clk,
  input wire logic                rst,
  input wire logic [1:0]          sig_present,
  input wire logic [1:0][2:0]     timing_offset_lines,
  input wire logic                ts_mode,
  input wire logic [1:0][NA-1:0]  alarm_status,
  input wire logic [1:0][1:0]     input_level,
  input wire logic [1:0]          led_colour,
  input wire logic                select_in2
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);

  // repetitions leave room for the two-flop synchroniser plus register stage
  property p_nosig;
    !sig_present[0] [*6] |-> alarm_status[0][0] && input_level[0] == 2'h1;
  endproperty
  property p_clean;
    (input_level[0] == 2'h0) [*3] |-> !select_in2;
  endproperty
  property p_l1;
    (input_level[0] == 2'h1 && input_level[1] != 2'h1) [*3] |-> select_in2;
  endproperty
  property p_l2_free;
    (input_level[0] == 2'h2 && input_level[1] == 2'h0) [*3] |-> select_in2;
  endproperty
  property p_l2_vs_l1;
    (input_level[0] == 2'h2 && input_level[1] == 2'h1) [*3] |-> !select_in2;
  endproperty
  // equal nonzero levels must never cause a changeover
  property p_keep;
    (input_level[0] != 2'h0 && input_level[1] == input_level[0]) [*3] |-> $stable(select_in2);
  endproperty
  property p_timing;
    (timing_offset_lines[0] > 3'h2 && !ts_mode) [*6] |-> alarm_status[0][3];
  endproperty
  property p_ts;
    ts_mode [*4] |-> alarm_status[0][NA-1:2] == '0 && alarm_status[1][NA-1:2] == '0;
  endproperty
  property p_led;
    (alarm_status == '0) [*3] |-> led_colour == 2'h0;
  endproperty

  a_nosig: assert property (p_nosig) else $error("no-signal alarm missing");
  a_clean: assert property (p_clean) else $error("clean input 1 not selected");
  a_l1: assert property (p_l1) else $error("input 2 not taken on level 1");
  a_l2_free: assert property (p_l2_free) else $error("free input 2 not taken");
  a_l2_vs_l1: assert property (p_l2_vs_l1) else $error("input 1 not kept");
  a_keep: assert property (p_keep) else $error("selection moved on equal levels");
  a_timing: assert property (p_timing) else $error("timing alarm missing");
  a_ts: assert property (p_ts) else $error("alarm shown in transport mode");
  a_led: assert property (p_led) else $error("indicator not green");

  c_switch: cover property ($rose(select_in2));
  c_ts: cover property (ts_mode [*4]);
  c_timing: cover property (alarm_status[0][3]);
endmodule // cad_top_properties

bind cad_top cad_top_properties #(.NA(NA)) u_props (
  .ref_clk, .rst, .sig_present, .timing_offset_lines, .ts_mode,
  .alarm_status, .input_level, .led_colour, .select_in2
);

// file: testbench/cad_src_model.sv
// analyser model for both monitored inputs: fault flags become pin values
// assumes flags change just after ref_clk edges; values sit one step off each limit
`timescale 1ns/100ps
module cad_src_model (
  input  wire logic              ref_clk,
  input  wire logic [1:0][7:0]   flt,
  input  wire logic              pcm_on,
  output logic      [1:0]        sig_present,
  output logic      [1:0]        vid_err,
  output logic      [1:0][2:0]   fmt_detected,
  output logic      [1:0][2:0]   timing_offset_lines,
  output logic      [1:0][9:0]   luma_mv,
  output logic      [1:0][3:0]   frame_diff,
  output logic      [1:0][3:0]   grp_present,
  output logic      [1:0][127:0] ch_level_db,
  output logic      [1:0][15:0]  ch_is_pcm
);
  // combinational, so pins follow flags in the step of the edge that set them
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      sig_present[i] = !flt[i][0];
      vid_err[i] = flt[i][1];
      fmt_detected[i] = flt[i][2] ? 3'h5 : 3'h3;
      timing_offset_lines[i] = flt[i][3] ? 3'h3 : 3'h2;
      luma_mv[i] = flt[i][4] ? 10'h027 : 10'h1f4;
      frame_diff[i] = flt[i][5] ? 4'h3 : 4'h4;
      grp_present[i] = {3'h7, !flt[i][6]};
      ch_level_db[i] = {{15{8'h80}}, flt[i][7] ? 8'h2f : 8'h80};
      ch_is_pcm[i] = {15'h7fff, pcm_on};
    end
  end
endmodule // cad_src_model

// file: testbench/tb_changeover_alarm_decision.sv
// self-checking bench for the changeover decision block
// assumes the analyser model on the far side and a shortened 4-cycle tick
`timescale 1ns/100ps
`include "cad_map.svh"
module tb_changeover_alarm_decision;
  localparam int TC = 4;
  localparam int NA = `CAD_NUM_ALARMS;
  logic                 ref_clk = 1'b0;
  logic                 rst = 1'b1;
  logic                 ts_mode = 1'b0;
  logic                 pcm_on = 1'b1;
  logic [1:0][7:0]      flt = '0;
  logic [1:0][NA-1:0]   alarm_enable = '1;
  logic [1:0][NA*2-1:0] alarm_level = '0;
  logic [1:0][NA*2-1:0] alarm_led;
  logic [1:0][2:0]      fmt_expected = {3'h3, 3'h3};
  logic [1:0][14:0]     viderr_dur = '0;
  logic [1:0][14:0]     black_set_dur = {2{15'h00a}};
  logic [1:0][14:0]     black_clr_dur = {2{15'h005}};
  logic [1:0][14:0]     freeze_set_dur = '0;
  logic [1:0][14:0]     freeze_clr_dur = '0;
  logic [1:0][14:0]     silence_dur = {2{15'h00a}};
  logic [1:0][59:0]     grp_dur = {8{15'h00a}};
  logic [1:0][9:0]      black_thresh_mv = {2{10'h028}};
  logic [1:0][3:0]      freeze_thresh = {2{4'h3}};
  logic [1:0][7:0]      silence_thresh_db = {2{8'h30}};
  logic [1:0]           sig_present, vid_err, led_colour;
  logic [1:0][2:0]      fmt_detected, timing_offset_lines;
  logic [1:0][9:0]      luma_mv;
  logic [1:0][3:0]      frame_diff, grp_present;
  logic [1:0][127:0]    ch_level_db;
  logic [1:0][15:0]     ch_is_pcm;
  logic [1:0][NA-1:0]   alarm_status;
  logic [1:0][1:0]      input_level;
  logic                 select_in2;
  int                   err_count = 0;
  int                   n_checks = 0;

  always #12.5 ref_clk = ~ref_clk;

  cad_src_model m_src (.ref_clk, .flt, .pcm_on, .sig_present, .vid_err, .fmt_detected,
    .timing_offset_lines, .luma_mv, .frame_diff, .grp_present, .ch_level_db, .ch_is_pcm);

  cad_top #(.TICK_CYCLES(TC)) uut (.ref_clk, .rst, .sig_present, .vid_err, .fmt_detected,
    .timing_offset_lines, .luma_mv, .frame_diff, .grp_present, .ch_level_db, .ch_is_pcm,
    .ts_mode, .alarm_enable, .alarm_level, .alarm_led, .fmt_expected, .viderr_dur,
    .black_thresh_mv, .black_set_dur, .black_clr_dur, .freeze_thresh, .freeze_set_dur,
    .freeze_clr_dur, .grp_dur, .silence_thresh_db, .silence_dur, .alarm_status,
    .input_level, .led_colour, .select_in2);

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // one qualified alarm on input 1: not early, raised in time, level off, colour, clear
  task automatic tq(input int k, input int b, input int d, input int u, input bit brk);
    viderr_dur[0] <= 15'(d);
    freeze_set_dur[0] <= 15'(d);
    cyc(2);
    flt[0][b] <= 1'b1;
    if (brk) begin
      cyc(u * TC / 2);
      flt[0][b] <= 1'b0;
      cyc(2);
      flt[0][b] <= 1'b1;
    end
    cyc(u * TC - 6);
    chk("early", 0, alarm_status[0][k]);
    cyc(22);
    chk("raised", 1, alarm_status[0][k]);
    chk("level off", 0, input_level[0]);
    if (k == 2 || k > 3) chk("led", k % 3 + 1, led_colour);
    flt[0][b] <= 1'b0;
    cyc(8);
    chk("clear hold", k == 4, alarm_status[0][k]);
    cyc(30);
    chk("cleared", 0, alarm_status[0][k]);
    $display("qualify alarm %0d done", k);
  endtask

  // every expected format against a detected 1080i50
  task automatic t_fmt();
    for (int e = 0; e < 8; e++) begin
      fmt_expected[0] <= 3'(e);
      cyc(50 * TC + 20);
      chk("format", !(e == 3 || e == 7), alarm_status[0][2]);
    end
    fmt_expected[0] <= 3'h3;
    cyc(8);
    $display("format table done");
  endtask

  task automatic t_ts();
    viderr_dur[0] <= '0;
    alarm_level[0][7:6] <= 2'h1;
    flt[0] <= 8'h0e;
    cyc(50 * TC + 20);
    chk("timing", 1, alarm_status[0][3]);
    chk("timing level", 0, input_level[0]);
    chk("timing sel", 0, select_in2);
    ts_mode <= 1'b1;
    cyc(8);
    chk("ts others", 0, alarm_status[0][NA-1:2]);
    chk("ts viderr", 1, alarm_status[0][1]);
    flt[0] <= '0;
    alarm_level[0][7:6] <= 2'h0;
    ts_mode <= 1'b0;
    cyc(8);
    $display("transport mode done");
  endtask

  task automatic t_pcm();
    pcm_on <= 1'b0;
    flt[0][7] <= 1'b1;
    cyc(60 * TC + 20);
    chk("non pcm", 0, alarm_status[0][10]);
    flt[0][7] <= 1'b0;
    pcm_on <= 1'b1;
    cyc(8);
    $display("non pcm done");
  endtask

  // level of each input set through the video error level, raised with zero duration
  task automatic t_sel();
    int cv[3] = '{0, 2, 1};
    int c;
    logic p;
    viderr_dur <= '0;
    alarm_enable[0][1:0] <= 2'h0;
    flt[0][0] <= 1'b1;
    cyc(10);
    chk("nosig level", 1, input_level[0]);
    chk("nosig sel", 1, select_in2);
    flt[0][0] <= 1'b0;
    cyc(10);
    chk("back sel", 0, select_in2);
    p = 1'b0;
    for (int a = 2; a >= 0; a--) begin
      for (int j = 0; j < 3; j++) begin
        c = cv[j];
        alarm_level[0][3:2] <= 2'(a);
        alarm_level[1][3:2] <= 2'(c);
        flt[0][1] <= (a != 0);
        flt[1][1] <= (c != 0);
        cyc(12);
        if (a == 0) p = 1'b0;
        else if (a == 1) p = (c == 1) ? p : 1'b1;
        else if (c != 2) p = (c == 0);
        chk("in1 level", a, input_level[0]);
        chk("in2 level", c, input_level[1]);
        chk("select", p, select_in2);
      end
    end
    flt <= '0;
    alarm_level <= '0;
    alarm_enable <= '1;
    cyc(10);
    $display("selection table done");
  endtask

  initial begin
    for (int k = 0; k < NA; k++) begin
      alarm_led[0][2*k+:2] = 2'(k % 3 + 1);
      alarm_led[1][2*k+:2] = 2'(k % 3 + 1);
    end
    cyc(16);
    rst <= 1'b0;
    cyc(8);
    chk("idle status in1", 0, alarm_status[0]);
    chk("idle status in2", 0, alarm_status[1]);
    chk("idle sel", 0, select_in2);
    chk("idle led", 0, led_colour);
    tq(1, 1, 10, 10, 0);
    tq(1, 1, 10, 10, 1);
    tq(1, 1, 100, 150, 0);
    tq(2, 2, 10, 50, 0);
    tq(4, 4, 10, 60, 0);
    tq(5, 5, 50, 50, 0);
    tq(5, 5, 100, 150, 0);
    tq(6, 6, 10, 10, 0);
    tq(10, 7, 10, 60, 0);
    t_fmt();
    t_ts();
    t_pcm();
    t_sel();
    give_verdict();
  end

  // hang guard, about four times the expected run
  initial begin
    cyc(20000);
    err_count++;
    give_verdict();
  end
endmodule // tb_changeover_alarm_decision
